/* scpd_ctrl.sv */
// Card pin control and card detect with an AXI4-Lite register slave
// Operation
// - Supply level output follows the two voltage select bits from software.
// - Writing the reset control bit drives the card reset pin to that level.
// - Reading the reset control bit returns the live reset pin level.
// - In automatic mode the serial engine drives card clock and data pins.
// - In manual mode clock and data pins follow their own software bits.
// - Insert or remove raises an interrupt only when its enable is set.
// - Both auxiliary pins work as general I/O, each with its own bit.
// - Insertion and removal are each recognised as separate events.
// - Switch type bit selects which detect level means card present.
// - Presence flag reads 1 while card present; software may clear it.
// - No debounce; every detect level change updates the presence flag.
// - Mode bit 1 selects automatic transfer, 0 selects manual pins.
// - After reset the serial interface receives, automatic mode off.
`timescale 1ns/100ps
`include "scpd_defs.svh"

module scpd_ctrl
    import scpd_pkg::*;
(
    // System
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Automatic serial engine
    input  wire scpd_serial_t auto_serial,
    output logic             serial_data_in,
    // Card pins
    output scpd_power_t      card_power,
    output logic             card_clock_pin,
    input  wire logic        card_serial_data_pin_in,
    output logic             card_serial_data_pin_out,
    output logic             card_serial_data_pin_oe_n,
    input  wire logic        card_reset_pin_in,
    input  wire logic        card_aux_pin_a_in,
    output logic             card_aux_pin_a_out,
    output logic             card_aux_pin_a_oe_n,
    input  wire logic        card_aux_pin_b_in,
    output logic             card_aux_pin_b_out,
    output logic             card_aux_pin_b_oe_n,
    input  wire logic        card_detect_input,
    // Interrupt
    output logic             card_irq
);

    // ----------------------------------------------------------------
    // Registers and synchronisers
    // ----------------------------------------------------------------
    logic [`SCPD_CTRL_WIDTH-1:0] card_control_register;
    logic [1:0]                  card_irq_enable;
    logic                        card_presence_flag;
    logic                        insert_flag;
    logic                        remove_flag;
    logic [1:0]                  det_sync;
    logic                        det_level;
    logic                        det_prev;
    logic                        present;
    logic                        insert_evt;
    logic                        remove_evt;
    logic [1:0]                  rst_sync;
    logic [1:0]                  auxa_sync;
    logic [1:0]                  auxb_sync;
    logic [1:0]                  data_sync;
    logic                        aw_held;
    logic                        w_held;
    logic [11:0]                 aw_addr;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        do_write;
    logic                        wr_ctrl;
    logic                        wr_stat;
    logic                        wr_ien;
    logic [31:0]                 next_rdata;
    logic                        next_rerr;

    // Detect, reset, aux and data pins come from outside aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_sync  <= 2'h0;
            rst_sync  <= 2'h0;
            auxa_sync <= 2'h0;
            auxb_sync <= 2'h0;
            data_sync <= 2'h3;
        end else begin
            det_sync  <= {det_sync[0], card_detect_input};
            rst_sync  <= {rst_sync[0], card_reset_pin_in};
            auxa_sync <= {auxa_sync[0], card_aux_pin_a_in};
            auxb_sync <= {auxb_sync[0], card_aux_pin_b_in};
            data_sync <= {data_sync[0], card_serial_data_pin_in};
        end
    end
    assign det_level = det_sync[1];
    assign serial_data_in = data_sync[1];

    // ----------------------------------------------------------------
    // Card detect
    // ----------------------------------------------------------------
    // Switch type 0: high means present; 1: low means present
    assign present    = det_level ^ card_control_register[`SCPD_CTRL_SWTYPE];
    assign insert_evt = present & ~det_prev;
    assign remove_evt = ~present & det_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_prev <= 1'b0;
        end else begin
            det_prev <= present;
        end
    end

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_presence_flag <= 1'b0;
            insert_flag        <= 1'b0;
            remove_flag        <= 1'b0;
        end else begin
            if (insert_evt) begin
                card_presence_flag <= 1'b1;
            end else if (remove_evt) begin
                card_presence_flag <= 1'b0;
            end else if (wr_stat && w_strb[0] && !w_data[`SCPD_STAT_PRES]) begin
                card_presence_flag <= 1'b0;
            end
            if (insert_evt) begin
                insert_flag <= 1'b1;
            end else if (wr_stat && w_strb[0] && w_data[`SCPD_STAT_INS]) begin
                insert_flag <= 1'b0;
            end
            if (remove_evt) begin
                remove_flag <= 1'b1;
            end else if (wr_stat && w_strb[0] && w_data[`SCPD_STAT_REM]) begin
                remove_flag <= 1'b0;
            end
        end
    end

    assign card_irq = (insert_flag & card_irq_enable[`SCPD_IEN_INS])
                    | (remove_flag & card_irq_enable[`SCPD_IEN_REM]);

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_power                <= '0;
            card_clock_pin            <= 1'b0;
            card_serial_data_pin_out  <= 1'b1;
            card_serial_data_pin_oe_n <= 1'b1;
            card_aux_pin_a_out        <= 1'b0;
            card_aux_pin_a_oe_n       <= 1'b1;
            card_aux_pin_b_out        <= 1'b0;
            card_aux_pin_b_oe_n       <= 1'b1;
        end else begin
            card_power.level <= {card_control_register[`SCPD_CTRL_VSEL_HI],
                                 card_control_register[`SCPD_CTRL_VSEL_LO]};
            card_power.rst   <= card_control_register[`SCPD_CTRL_RST];
            if (card_control_register[`SCPD_CTRL_MODE]) begin
                card_clock_pin            <= auto_serial.clk;
                card_serial_data_pin_out  <= auto_serial.data_out;
                card_serial_data_pin_oe_n <= auto_serial.data_oe_n;
            end else begin
                card_clock_pin            <= card_control_register[`SCPD_CTRL_CLK];
                card_serial_data_pin_out  <= card_control_register[`SCPD_CTRL_DATA];
                // Open-drain style: only a low level is driven
                card_serial_data_pin_oe_n <= card_control_register[`SCPD_CTRL_DATA];
            end
            card_aux_pin_a_out  <= card_control_register[`SCPD_CTRL_AUXA];
            card_aux_pin_a_oe_n <= ~card_control_register[`SCPD_CTRL_AUXA_OE];
            card_aux_pin_b_out  <= card_control_register[`SCPD_CTRL_AUXB];
            card_aux_pin_b_oe_n <= ~card_control_register[`SCPD_CTRL_AUXB_OE];
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;
    assign wr_ctrl       = do_write && aw_addr[11:2] == 10'(`SCPD_OFF_CTRL >> 2);
    assign wr_stat       = do_write && aw_addr[11:2] == 10'(`SCPD_OFF_STAT >> 2);
    assign wr_ien        = do_write && aw_addr[11:2] == 10'(`SCPD_OFF_IEN >> 2);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 12'h000;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCPD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ctrl || wr_stat || wr_ien) ? `SCPD_RESP_OKAY
                                                               : `SCPD_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_control_register <= `SCPD_CTRL_RESET;
            card_irq_enable       <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                if (w_strb[0]) begin
                    card_control_register[7:0] <= w_data[7:0];
                end
                if (w_strb[1]) begin
                    card_control_register[10:8] <= w_data[10:8];
                end
            end
            if (wr_ien && w_strb[0]) begin
                card_irq_enable <= w_data[1:0];
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rerr  = 1'b0;
        case (s_axi_araddr[11:2])
            10'(`SCPD_OFF_CTRL >> 2): begin
                next_rdata[`SCPD_CTRL_WIDTH-1:0] = card_control_register;
                next_rdata[`SCPD_CTRL_RST]       = rst_sync[1];
                next_rdata[`SCPD_CTRL_AUXA]      = auxa_sync[1];
                next_rdata[`SCPD_CTRL_AUXB]      = auxb_sync[1];
            end
            10'(`SCPD_OFF_STAT >> 2): begin
                next_rdata[`SCPD_STAT_PRES]  = card_presence_flag;
                next_rdata[`SCPD_STAT_INS]   = insert_flag;
                next_rdata[`SCPD_STAT_REM]   = remove_flag;
                next_rdata[`SCPD_STAT_LEVEL] = present;
            end
            10'(`SCPD_OFF_IEN >> 2): begin
                next_rdata[1:0] = card_irq_enable;
            end
            default: begin
                next_rerr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SCPD_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= next_rerr ? `SCPD_RESP_SLVERR : `SCPD_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_SUPPLY: assert property (@(posedge aclk) disable iff (!aresetn)
        card_power.level == {$past(card_control_register[1]), $past(card_control_register[0])})
        else $error("Supply level does not follow select bits");
    AST_RESET_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctrl && w_strb[0] |=> ##1 card_power.rst == $past(w_data[`SCPD_CTRL_RST], 2))
        else $error("Reset pin not driven to written level");
    AST_AUTO_CLK: assert property (@(posedge aclk) disable iff (!aresetn)
        card_control_register[`SCPD_CTRL_MODE] |=> card_clock_pin == $past(auto_serial.clk))
        else $error("Automatic mode clock not from serial engine");
    AST_MANUAL_CLK: assert property (@(posedge aclk) disable iff (!aresetn)
        !card_control_register[`SCPD_CTRL_MODE]
        |=> card_clock_pin == $past(card_control_register[`SCPD_CTRL_CLK]))
        else $error("Manual mode clock not from control bit");
    AST_IRQ_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        card_irq |-> (insert_flag && card_irq_enable[0]) || (remove_flag && card_irq_enable[1]))
        else $error("Interrupt without enabled event");
    AST_IRQ_RAISE: assert property (@(posedge aclk) disable iff (!aresetn)
        insert_evt && card_irq_enable[`SCPD_IEN_INS] && !wr_ien |=> card_irq)
        else $error("Enabled insertion raised no interrupt");
    AST_INSERT_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
        insert_evt |=> insert_flag && card_presence_flag)
        else $error("Insertion not recorded");
    AST_REMOVE_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
        remove_evt |=> remove_flag && !card_presence_flag)
        else $error("Removal not recorded");
    AST_SYNC_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(det_level) && !card_control_register[`SCPD_CTRL_SWTYPE]
        && $stable(card_control_register[`SCPD_CTRL_SWTYPE]) |=> card_presence_flag)
        else $error("Detect edge did not reach the presence flag");

endmodule

/* scpd_defs.svh */
// Register offsets, field positions and reset values for the card pin block
`ifndef SCPD_DEFS_SVH
`define SCPD_DEFS_SVH

`define SCPD_OFF_CTRL      12'h000
`define SCPD_OFF_STAT      12'h004
`define SCPD_OFF_IEN       12'h008

`define SCPD_CTRL_VSEL_LO  0
`define SCPD_CTRL_VSEL_HI  1
`define SCPD_CTRL_RST      2
`define SCPD_CTRL_CLK      3
`define SCPD_CTRL_DATA     4
`define SCPD_CTRL_AUXA     5
`define SCPD_CTRL_AUXB     6
`define SCPD_CTRL_MODE     7
`define SCPD_CTRL_SWTYPE   8
`define SCPD_CTRL_AUXA_OE  9
`define SCPD_CTRL_AUXB_OE  10
`define SCPD_CTRL_WIDTH    11

`define SCPD_STAT_PRES     0
`define SCPD_STAT_INS      1
`define SCPD_STAT_REM      2
`define SCPD_STAT_LEVEL    3

`define SCPD_IEN_INS       0
`define SCPD_IEN_REM       1

// Manual data bit starts released so the data line idles in reception
`define SCPD_CTRL_RESET    11'h010
`define SCPD_RESP_OKAY     2'b00
`define SCPD_RESP_SLVERR   2'b10

`endif

/* scpd_pkg.sv */
// Types shared by the card pin and detect block
package scpd_pkg;
    typedef struct packed {
        logic       clk;
        logic       data_out;
        logic       data_oe_n;
    } scpd_serial_t;

    typedef struct packed {
        logic [1:0] level;
        logic       rst;
    } scpd_power_t;
endpackage

/* scpd_card_model.sv */
// Far-side model: smart card pins and card detect switch
`timescale 1ns/100ps

module scpd_card_model
    import scpd_pkg::*;
(
    // Clock
    input  wire logic        aclk,
    // Bench commands
    input  wire logic        card_in,
    input  wire logic        closed_sw,
    input  wire logic        card_tx,
    input  wire logic        card_bit,
    // From the device
    input  wire scpd_power_t pwr,
    input  wire logic        d_out,
    input  wire logic        d_oen,
    input  wire logic        a_out,
    input  wire logic        a_oen,
    input  wire logic        b_out,
    input  wire logic        b_oen,
    // Back to the device
    output logic             det,
    output logic             rst_lvl,
    output logic             d_lvl,
    output logic             a_lvl,
    output logic             b_lvl
);
    // ----------------------------------------
    // Pin levels
    // ----------------------------------------
    logic flt = 1'b0;

    // Released aux lines float; a toggling level keeps stale reads visible
    always @(posedge aclk) flt <= ~flt;
    // Switch type only flips which level means present
    assign det     = card_in ^ closed_sw;
    assign rst_lvl = pwr.rst;
    // Open drain with pull-up; the card talks only when commanded
    assign d_lvl   = (d_oen ? 1'b1 : d_out) & (card_tx ? card_bit : 1'b1);
    assign a_lvl   = a_oen ? flt : a_out;
    assign b_lvl   = b_oen ? flt : b_out;
endmodule

/* scpd_ctrl_bench.sv */
// Self-checking bench for the card pin and detect block
`timescale 1ns/100ps
`include "scpd_defs.svh"

`define CHECK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module scpd_ctrl_bench
    import scpd_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    logic  [11:0] awaddr = 12'h000;
    logic  [11:0] araddr = 12'h000;
    logic  [31:0] wdata = 32'h0;
    logic  [3:0]  wstrb = 4'hf;
    logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
    logic         arvalid = 1'b0, rready = 1'b1;
    logic         awready, wready, bvalid, arready, rvalid;
    logic  [1:0]  bresp, rresp, r;
    logic  [31:0] rdata, rd, m, k;
    scpd_serial_t aser = 3'b111;
    scpd_power_t  pwr;
    logic         clk_pin, d_in, d_out, d_oen, rst_in, ser_in, irq, det;
    logic         a_in, a_out, a_oen, b_in, b_out, b_oen, e_oen, e_out, e_lvl;
    logic         card_in = 1'b0, closed_sw = 1'b0, card_tx = 1'b0, card_bit = 1'b0;
    int           fails = 0, n_checks = 0;

    always #2.5 aclk = ~aclk;

    scpd_ctrl u_scpd_ctrl (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .auto_serial(aser), .serial_data_in(ser_in), .card_power(pwr),
        .card_clock_pin(clk_pin), .card_serial_data_pin_in(d_in),
        .card_serial_data_pin_out(d_out), .card_serial_data_pin_oe_n(d_oen),
        .card_reset_pin_in(rst_in), .card_aux_pin_a_in(a_in), .card_aux_pin_a_out(a_out),
        .card_aux_pin_a_oe_n(a_oen), .card_aux_pin_b_in(b_in), .card_aux_pin_b_out(b_out),
        .card_aux_pin_b_oe_n(b_oen), .card_detect_input(det), .card_irq(irq));

    scpd_card_model u_scpd_card_model (
        .aclk(aclk), .card_in(card_in), .closed_sw(closed_sw), .card_tx(card_tx),
        .card_bit(card_bit), .pwr(pwr), .d_out(d_out), .d_oen(d_oen), .a_out(a_out),
        .a_oen(a_oen), .b_out(b_out), .b_oen(b_oen), .det(det), .rst_lvl(rst_in),
        .d_lvl(d_in), .a_lvl(a_in), .b_lvl(b_in));

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Ready is read at the falling edge; inputs only move at rising edges
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             output logic [1:0] rs);
        logic aw_hit, w_hit, b_hit;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
        end while (!b_hit);
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] rs);
        logic ar_hit, r_hit;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ar_hit) arvalid <= 1'b0;
        end while (!r_hit);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e,
                          input logic [31:0] msk = ALL);
        axi_read(a, rd, r);
        `CHECK(nm, e & msk, rd & msk)
        `CHECK("read resp", `SCPD_RESP_OKAY, r)
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic irq_is(input logic e);
        @(negedge aclk);
        `CHECK("irq", e, irq)
        @(posedge aclk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'hb57d));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(3);
        // Engine holds its clock high, yet manual mode must win after reset
        irq_is(1'b0);
        `CHECK("clock pin", 1'b0, clk_pin)
        `CHECK("power", 3'h0, pwr)
        `CHECK("oe_n", 3'h7, {d_oen, a_oen, b_oen})
        rd_chk("ctrl", `SCPD_OFF_CTRL, 32'h10, 32'hffff_ff9f);
        rd_chk("stat", `SCPD_OFF_STAT, 32'h0);
        rd_chk("ien", `SCPD_OFF_IEN, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            m = $urandom() & 32'h0000_06ff;
            aser <= scpd_serial_t'(3'($urandom()));
            card_tx <= 1'($urandom());
            card_bit <= 1'($urandom());
            axi_write(`SCPD_OFF_CTRL, m, r);
            `CHECK("write resp", `SCPD_RESP_OKAY, r)
            cyc(4);
            @(negedge aclk);
            e_oen = m[7] ? aser.data_oe_n : m[4];
            e_out = m[7] ? aser.data_out : 1'b0;
            e_lvl = (e_oen ? 1'b1 : e_out) & (card_tx ? card_bit : 1'b1);
            `CHECK("supply", m[1:0], pwr.level)
            `CHECK("reset pin", m[2], pwr.rst)
            `CHECK("clock pin", m[7] ? aser.clk : m[3], clk_pin)
            `CHECK("data oe_n", e_oen, d_oen)
            if (!e_oen) `CHECK("data out", e_out, d_out)
            `CHECK("data in", e_lvl, ser_in)
            `CHECK("aux out", {m[5], m[6]}, {a_out, b_out})
            `CHECK("aux oe_n", ~{m[9], m[10]}, {a_oen, b_oen})
            @(posedge aclk);
            k = ALL & ~{25'h0, ~m[10], ~m[9], 5'h0};
            rd_chk("ctrl", `SCPD_OFF_CTRL, m, k);
        end
        $display("test pins done");
        axi_write(`SCPD_OFF_CTRL, 32'h80, r);
        // Engine clock at 125 ns: 12 and 13 cycle half periods
        for (int h = 0; h < 6; h++) begin
            aser.clk <= ~aser.clk;
            cyc(3);
            irq_is(1'b0);
            `CHECK("auto clock", aser.clk, clk_pin)
            cyc(8 + h % 2);
        end
        axi_write(12'h00c, 32'h0000_07ff, r);
        `CHECK("bad wr resp", `SCPD_RESP_SLVERR, r)
        axi_read(12'h00c, rd, r);
        `CHECK("bad rd resp", `SCPD_RESP_SLVERR, r)
        `CHECK("bad rd data", 32'h0, rd)
        rd_chk("ctrl kept", `SCPD_OFF_CTRL, 32'h80, 32'hffff_ff9f);
        $display("test link and unmapped done");
        // Timing counters sit outside this block; nothing to set up here
        for (int st = 0; st < 2; st++) begin
            m = 32'(st) << `SCPD_CTRL_SWTYPE;
            closed_sw <= st[0];
            axi_write(`SCPD_OFF_CTRL, m, r);
            axi_write(`SCPD_OFF_IEN, 32'h1, r);
            cyc(8); // software debounce wait
            axi_write(`SCPD_OFF_STAT, 32'h6, r);
            card_in <= 1'b1;
            irq_is(1'b0);
            irq_is(1'b0);
            cyc(5);
            rd_chk("stat ins", `SCPD_OFF_STAT, 32'hb);
            irq_is(1'b1);
            axi_write(`SCPD_OFF_CTRL, m | 32'h7, r); // activation by software
            axi_write(`SCPD_OFF_STAT, 32'h3, r);
            irq_is(1'b0);
            axi_write(`SCPD_OFF_STAT, 32'h0, r);
            rd_chk("stat clr", `SCPD_OFF_STAT, 32'h8);
            card_in <= 1'b0;
            cyc(6);
            axi_write(`SCPD_OFF_CTRL, m, r); // deactivation by software
            rd_chk("stat rem", `SCPD_OFF_STAT, 32'h4);
            irq_is(1'b0);
            axi_write(`SCPD_OFF_IEN, 32'h3, r);
            irq_is(1'b1);
            axi_write(`SCPD_OFF_STAT, 32'h4, r);
            irq_is(1'b0);
            card_in <= 1'b1;
            cyc(4);
            card_in <= 1'b0;
            cyc(8);
            rd_chk("stat glitch", `SCPD_OFF_STAT, 32'h6);
        end
        $display("test detect done");
        print_verdict();
    end

    // Tests need a few hundred cycles; this limit leaves wide margin
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        print_verdict();
    end
endmodule
